// >>> include/nvsc_pkg.sv
// Package for the memory-pin controller: sequence addresses, pin timing and durations.
// Assumes a 25 MHz system clock on mclk.
package nvsc_pkg;
  localparam int CLK_MHZ = 25;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int SEQ_LEN = 6;
  localparam int MATCH_W = 14;
  localparam logic [ADDR_W-1:0] SEQ_A0 = 15'h0e38;
  localparam logic [ADDR_W-1:0] SEQ_A1 = 15'h31c7;
  localparam logic [ADDR_W-1:0] SEQ_A2 = 15'h03e0;
  localparam logic [ADDR_W-1:0] SEQ_A3 = 15'h3c1f;
  localparam logic [ADDR_W-1:0] SEQ_A4 = 15'h303f;
  localparam logic [ADDR_W-1:0] SEQ_SAVE = 15'h0fc0;
  localparam logic [ADDR_W-1:0] SEQ_RESTORE = 15'h0c63;
  localparam int CYCLE_NS = 80;
  localparam int CYCLE_CLKS = (CYCLE_NS * CLK_MHZ + 999) / 1000;
  localparam int SAVE_DURATION_US = 10000;
  localparam int RESTORE_DURATION_US = 20;
  localparam int POWERUP_RESTORE_DURATION_US = 550;
  localparam int SAVE_CLKS = SAVE_DURATION_US * CLK_MHZ;
  localparam int RESTORE_CLKS = RESTORE_DURATION_US * CLK_MHZ;
  localparam int POWERUP_CLKS = POWERUP_RESTORE_DURATION_US * CLK_MHZ;
  localparam int TMR_W = 24;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_SAVE = 2'h2;
  localparam logic [1:0] OP_RESTORE = 2'h3;
  typedef enum {ST_PWRUP, ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_SEQ, ST_WAIT,
                ST_HWSAVE, ST_HWREL} nvsc_state_type;
endpackage

// >>> hdl/nvsc_timer.sv
// Down-counting busy timer used for every nonvolatile duration.
// Assumes load is a one-cycle pulse from the same clock domain.
`timescale 1ns/100ps
module nvsc_timer
  import nvsc_pkg::*;
#(
  parameter int W = TMR_W
) (
  input  wire logic         mclk,   // System clock.
  input  wire logic         rst_b,  // Synchronous reset, active low.
  input  wire logic         load,   // Start pulse.
  input  wire logic [W-1:0] count,  // Cycles to wait.
  output logic              done    // Level high while idle.
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  assign cnt_nxt = load ? count : ((cnt_r != '0) ? cnt_r - 1'b1 : cnt_r);
  assign done = (cnt_r == '0) && !load;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// >>> hdl/nvsc_host.sv
// Host controller that drives the memory's asynchronous pins.
// Assumes the memory's busy line has an external pull-up and arrives asynchronously.
//
// Operation
// R1: Read: enable, output enable low, write high.
// R2: Drive fifteen address bits each access.
// R3: Hold address steady while read data sampled.
// R4: Write: enable and write low, busy high.
// R5: Address stable across write; data at rising.
// R6: Output enable stays high during writes.
// R7: Power-up restore pending after reset.
// R8: Wait powerup restore duration before access.
// R9: Save: six enable-controlled sequence reads.
// R10: No other access inside a sequence.
// R11: All access held until save finishes; in idle, reads are still taken during an automatic save (busy line low).
// R12: Sequence accesses are reads, output enable high.
// R13: Wait save duration after sixth address.
// R14: Restore sequence ends with address 0c63.
// R15: Wait restore duration after restore sequence.
// R16: Automatic save seen as busy line low.
// R17: Write flag decides line-requested save waits.
// R18: Software saves always wait full duration.
// R19: No host access during any transfer; in idle, reads are still taken during an automatic save (busy line low).
// R20: Only lower fourteen address bits matter.
// R21: Busy line low means save in progress.
// R22: No write starts while busy line low.
// R23: Wait busy high before next access; in idle, writes, saves and restores wait, reads are still taken while it is low.
// R24: Parameterised timers hold off host accesses.
`timescale 1ns/100ps
module nvsc_host
  import nvsc_pkg::*;
#(
  parameter int SAVE_CYC    = SAVE_CLKS,
  parameter int RESTORE_CYC = RESTORE_CLKS,
  parameter int POWERUP_CYC = POWERUP_CLKS
) (
  input  wire logic              mclk,        // System clock.
  input  wire logic              rst_b,       // Synchronous reset, active low.
  input  wire logic              reqValid,    // Request strobe.
  input  wire logic [1:0]        reqOp,       // Read, write, save or restore.
  input  wire logic [ADDR_W-1:0] reqAddr,     // Byte address.
  input  wire logic [DATA_W-1:0] reqData,     // Write byte.
  input  wire logic              hwSaveReq,   // Ask for a line-requested save.
  output logic                   reqReady,    // Idle and able to take a request.
  output logic                   rspValid,    // One-cycle completion pulse.
  output logic [DATA_W-1:0]      rspData,     // Read byte.
  output logic                   wroteFlag,   // Write since last nonvolatile cycle.
  output logic [ADDR_W-1:0]      address_lines, // Address pins.
  output logic [DATA_W-1:0]      dataOut,     // Data pins, driven value.
  output logic                   dataOe,      // Data pins, high while driving.
  input  wire logic [DATA_W-1:0] dataIn,      // Data pins, sensed value.
  output logic                   chipEn_b,    // Chip enable, active low.
  output logic                   outEn_b,     // Output enable, active low.
  output logic                   writeEn_b,   // Write enable, active low.
  output logic                   hwSaveOut,   // Busy line driven low value.
  output logic                   hwSaveOe,    // Busy line, high while pulling low.
  input  wire logic              hw_save_busy_n // Busy line, sensed level.
);
  // ----------------------------------------------------------------
  // Pin synchroniser and shared decode
  // ----------------------------------------------------------------
  logic busyMeta_r, busySync_r;
  always_ff @(posedge mclk) begin
    busyMeta_r <= hw_save_busy_n;
    busySync_r <= busyMeta_r;
  end

  function automatic logic [ADDR_W-1:0] seqAddr(input logic [2:0] idx, input logic rst);
    case (idx)
      3'h0: seqAddr = SEQ_A0;
      3'h1: seqAddr = SEQ_A1;
      3'h2: seqAddr = SEQ_A2;
      3'h3: seqAddr = SEQ_A3;
      3'h4: seqAddr = SEQ_A4;
      default: seqAddr = rst ? SEQ_RESTORE : SEQ_SAVE; // R14
    endcase
  endfunction

  nvsc_state_type state_r, state_nxt;
  logic [1:0]        op_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [2:0]        seqIdx_r;
  logic [7:0]        phase_r;
  logic              tmrLoad;
  logic [TMR_W-1:0]  tmrCount;
  logic              tmrDone;
  logic              busyLow;
  logic              phaseDone;
  logic              take;
  logic              isSeq;
  logic              seqLast;
  logic              isWrite;
  logic              useSeq;
  logic [2:0]        seqPickIdx;
  logic              seqPickRst;
  logic [ADDR_W-1:0] seqPick;
  logic [ADDR_W-1:0] addrPick;

  assign busyLow   = !busySync_r;
  assign phaseDone = (phase_r == 8'(CYCLE_CLKS - 1));
  // Writes are withheld while the busy line is low; reads may still pass.
  assign take    = (state_r == ST_IDLE) && reqValid && tmrDone &&
                   !(busyLow && (reqOp != OP_READ)); // R22
  assign isSeq   = (op_r == OP_SAVE) || (op_r == OP_RESTORE);
  assign seqLast = (seqIdx_r == 3'(SEQ_LEN - 1));
  assign isWrite = (op_r == OP_WRITE);
  // A new request picks its pin address from its own opcode, never from the previous one.
  assign useSeq     = take ? reqOp[1] : isSeq;
  assign seqPickIdx = take ? 3'h0 : seqIdx_r + ((state_r == ST_SEQ) ? 3'h1 : 3'h0);
  assign seqPickRst = take ? reqOp[0] : op_r[0];
  assign seqPick    = seqAddr(seqPickIdx, seqPickRst); // R14
  // Upper address bit is a don't-care for sequences; drive it low.
  assign addrPick   = useSeq ? {1'b0, seqPick[MATCH_W-1:0]} : // R20
                      (take ? reqAddr : addr_r); // R2

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    tmrLoad   = 1'b0;
    tmrCount  = '0;
    unique case (state_r)
      ST_PWRUP: begin
        tmrLoad   = 1'b1; // R7
        tmrCount  = TMR_W'(POWERUP_CYC); // R8
        state_nxt = ST_WAIT;
      end
      ST_IDLE: begin
        if (hwSaveReq && !busyLow) begin
          state_nxt = ST_HWSAVE;
        end else if (busyLow && reqValid && (reqOp != OP_READ)) begin
          state_nxt = ST_IDLE; // R16
        end else if (take) begin
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP:  if (phaseDone) state_nxt = ST_STROBE; // R5
      ST_STROBE: if (phaseDone) state_nxt = ST_HOLD;
      ST_HOLD: begin
        if (phaseDone) begin
          if (isSeq && !seqLast) begin
            state_nxt = ST_SEQ; // R10
          end else if (isSeq) begin
            tmrLoad   = 1'b1; // R13
            tmrCount  = (op_r == OP_SAVE) ? TMR_W'(SAVE_CYC) : TMR_W'(RESTORE_CYC); // R18 R15
            state_nxt = ST_WAIT;
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_SEQ:    state_nxt = ST_SETUP;
      ST_WAIT:   if (tmrDone && !busyLow) state_nxt = ST_IDLE; // R11 R19 R24
      ST_HWSAVE: begin
        tmrLoad   = 1'b1; // R17
        tmrCount  = wroteFlag ? TMR_W'(SAVE_CYC) : TMR_W'(1);
        state_nxt = ST_HWREL;
      end
      ST_HWREL:  if (tmrDone && !busyLow) state_nxt = ST_IDLE; // R21 R23
      default:   state_nxt = ST_IDLE;
    endcase
  end

  nvsc_timer #(.W(TMR_W)) u_timer (
    .mclk  (mclk),
    .rst_b (rst_b),
    .load  (tmrLoad),
    .count (tmrCount),
    .done  (tmrDone)
  );

  // ----------------------------------------------------------------
  // Registers and pins
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_r  <= ST_PWRUP;
      op_r     <= OP_READ;
      addr_r   <= '0;
      wdata_r  <= '0;
      seqIdx_r <= '0;
      phase_r  <= '0;
    end else begin
      state_r <= state_nxt;
      phase_r <= (state_nxt != state_r) ? 8'h00 : phase_r + 8'h01;
      if (take) begin
        op_r     <= reqOp;
        addr_r   <= reqAddr;
        wdata_r  <= reqData;
        seqIdx_r <= '0;
      end else if (state_r == ST_SEQ) begin
        seqIdx_r <= seqIdx_r + 3'h1; // R9
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      address_lines <= '0;
      dataOut       <= '0;
      dataOe        <= 1'b0;
      chipEn_b      <= 1'b1;
      outEn_b       <= 1'b1;
      writeEn_b     <= 1'b1;
      hwSaveOut     <= 1'b0;
      hwSaveOe      <= 1'b0;
      reqReady      <= 1'b0;
      rspValid      <= 1'b0;
      rspData       <= '0;
      wroteFlag     <= 1'b0;
    end else begin
      address_lines <= (state_nxt == ST_SETUP || state_nxt == ST_STROBE ||
                        state_nxt == ST_HOLD) ? addrPick : address_lines; // R3
      chipEn_b  <= !(state_nxt == ST_STROBE); // R1 R4
      outEn_b   <= !(state_nxt == ST_STROBE && !isWrite && !isSeq); // R6 R12
      writeEn_b <= !(state_nxt == ST_STROBE && isWrite);
      dataOe    <= (state_nxt == ST_STROBE || state_nxt == ST_HOLD) && isWrite;
      dataOut   <= wdata_r;
      hwSaveOut <= 1'b0;
      hwSaveOe  <= (state_nxt == ST_HWSAVE) || (state_nxt == ST_HWREL && !tmrDone);
      reqReady  <= (state_nxt == ST_IDLE);
      if (state_r == ST_STROBE && phaseDone && !isWrite) begin
        rspData <= dataIn;
      end
      rspValid <= (state_r == ST_HOLD && phaseDone && !isSeq) ||
                  (state_r != ST_IDLE && state_nxt == ST_IDLE && state_r != ST_HOLD);
      if (state_r == ST_STROBE && isWrite) begin
        wroteFlag <= 1'b1;
      end else if (tmrLoad && state_r != ST_PWRUP) begin
        wroteFlag <= 1'b0;
      end
    end
  end
endmodule

// >>> sim/nvsc_mem_model.sv
// Behavioural shadow memory facing the host controller's pins.
// Assumes the bench resolves the data and busy wires from all drivers.
`timescale 1ns/100ps
module nvsc_mem_model
  import nvsc_pkg::*;
#(
  parameter int SAVE_T = 16,
  parameter int RCL_T  = 16,
  parameter int PWR_T  = 16
) (
  input  wire logic        mclk,      // Times the transfers and captures the last driven byte.
  input  wire logic [14:0] addr,      // Address pins.
  input  wire logic [7:0]  dq,        // Resolved data wire.
  input  wire logic        chipEn_b,  // Chip enable.
  input  wire logic        outEn_b,   // Output enable.
  input  wire logic        writeEn_b, // Write enable.
  input  wire logic        busyN,     // Resolved busy wire.
  input  wire logic        capLow,    // High while the capacitor is below the switch threshold.
  output logic [7:0]       mQ,        // Data driven, or inverted filler.
  output logic             mOe,       // High while driving data.
  output logic             pullLow    // High while pulling busy low.
);
  // ----
  // Storage and transfers
  // ----
  logic [7:0]  mem [0:32767];
  logic [7:0]  nv  [0:32767];
  logic [14:0] seqTab [0:4] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
  logic [7:0]  lastQ = 8'h00;
  logic [2:0]  seqIdx = 3'h0;
  logic        written = 1'b0;
  logic        weSeen = 1'b0;
  int          tmr = PWR_T;
  wire         idle = (tmr == 0) && busyN;
  wire         wrOff = chipEn_b | writeEn_b;
  initial pullLow = 1'b0;
  // Released data lines show the inverse of the last byte, so stale reads are caught.
  assign mOe = idle && !chipEn_b && !outEn_b && writeEn_b;
  assign mQ  = mOe ? mem[addr] : ~lastQ;
  always @(posedge mclk) begin
    if (mOe) lastQ <= mQ;
    if (tmr > 0) tmr <= tmr - 1;
    else if (pullLow) pullLow <= 1'b0;
    if ((capLow || !busyN) && !pullLow && tmr == 0 && written) begin
      nv = mem;
      written = 1'b0;
      pullLow <= 1'b1;
      tmr <= SAVE_T;
    end
  end
  always @(posedge wrOff) if (idle) begin
    mem[addr] = dq;
    written = 1'b1;
    seqIdx = 3'h0;
  end
  // A strobe that carried a write is no sequence read, whichever pin is seen rising first.
  always @(negedge writeEn_b) weSeen = 1'b1;
  always @(posedge chipEn_b) begin
    if (idle && !weSeen) begin
      if (seqIdx == 3'h5 && addr[13:0] == SEQ_SAVE[13:0]) begin
        nv = mem;
        written = 1'b0;
        pullLow = 1'b1;
        tmr = SAVE_T;
      end else if (seqIdx == 3'h5 && addr[13:0] == SEQ_RESTORE[13:0]) begin
        mem = nv;
        written = 1'b0;
        tmr = RCL_T;
      end
      seqIdx = (seqIdx < 3'h5 && addr[13:0] == seqTab[seqIdx][13:0]) ? seqIdx + 3'h1 :
               (addr[13:0] == SEQ_A0[13:0]) ? 3'h1 : 3'h0;
    end
    weSeen = 1'b0;
  end
endmodule

// >>> sim/nvsc_host_assertions.sv
// Concurrent checks on the memory-pin controller's ports.
// Assumes it is bound to every instance of nvsc_host.
`timescale 1ns/100ps
module nvsc_host_assertions
  import nvsc_pkg::*;
#(
  parameter int POWERUP_CYC = 20
) (
  input logic              mclk,          // System clock.
  input logic              rst_b,         // Synchronous reset, active low.
  input logic              reqReady,      // Idle.
  input logic              wroteFlag,     // Written since last transfer.
  input logic [ADDR_W-1:0] address_lines, // Address pins.
  input logic [DATA_W-1:0] dataOut,       // Data pins, driven value.
  input logic              dataOe,        // Data pins driven.
  input logic              chipEn_b,      // Chip enable.
  input logic              outEn_b,       // Output enable.
  input logic              writeEn_b,     // Write enable.
  input logic              hwSaveOut,     // Busy line value.
  input logic              hwSaveOe       // Busy line pulled.
);
  // ----
  // Properties
  // ----
  int upCnt_r;
  always_ff @(posedge mclk) begin
    if (!rst_b) upCnt_r <= 0;
    else if (upCnt_r < POWERUP_CYC) upCnt_r <= upCnt_r + 1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  rd_wr_excl_a: assert property (!chipEn_b && !outEn_b |-> writeEn_b)
    else $error("Read strobe overlaps write strobe.");
  wr_drive_a: assert property (!writeEn_b |-> dataOe)
    else $error("Write without driven data.");
  wr_hold_a: assert property (!writeEn_b && !$past(writeEn_b) |->
    $stable(address_lines) && $stable(dataOut))
    else $error("Address or data moved during write.");
  rd_addr_a: assert property (!outEn_b && !$past(outEn_b) |-> $stable(address_lines))
    else $error("Address moved during read.");
  oe_contend_a: assert property (!outEn_b |-> !dataOe)
    else $error("Data contention.");
  pwrup_wait_a: assert property (reqReady |-> upCnt_r >= POWERUP_CYC - 1)
    else $error("Ready before power-up restore time.");
  busy_short_a: assert property ($rose(hwSaveOe) && !wroteFlag && !$past(wroteFlag) |->
    ##3 !hwSaveOe)
    else $error("Busy held without a write.");
  busy_low_a: assert property (hwSaveOe |-> !hwSaveOut)
    else $error("Busy line driven high.");
  wrote_set_a: assert property ($rose(writeEn_b) |-> ##[0:6] wroteFlag)
    else $error("Write flag not set.");
  cover property ($rose(reqReady));
  cover property (!writeEn_b);
  cover property ($rose(hwSaveOe));
endmodule
bind nvsc_host nvsc_host_assertions #(.POWERUP_CYC(POWERUP_CYC)) nvsc_host_assertions_i (
  .mclk(mclk), .rst_b(rst_b), .reqReady(reqReady), .wroteFlag(wroteFlag),
  .address_lines(address_lines), .dataOut(dataOut), .dataOe(dataOe), .chipEn_b(chipEn_b),
  .outEn_b(outEn_b), .writeEn_b(writeEn_b), .hwSaveOut(hwSaveOut), .hwSaveOe(hwSaveOe));

// >>> sim/nvsc_host_tb.sv
// Self-checking bench: controller against the behavioural shadow memory.
// Assumes the package, model and checker are compiled first.
`timescale 1ns/100ps
module nvsc_host_tb
  import nvsc_pkg::*;
;
  // ----
  // Wiring
  // ----
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        reqValid = 1'b0;
  logic [1:0]  reqOp = 2'h0;
  logic [14:0] reqAddr = 15'h0000;
  logic [7:0]  reqData = 8'h00;
  logic        hwSaveReq = 1'b0;
  logic        capLow = 1'b0;
  logic        reqReady, rspValid, wroteFlag, dataOe, chipEn_b, outEn_b, writeEn_b;
  logic        hwSaveOut, hwSaveOe, mOe, pullLow;
  logic [7:0]  rspData, dataOut, mQ;
  logic [14:0] addrLines;
  logic [14:0] ta [0:2] = '{15'h0000, 15'h7fff, 15'h4e38};
  logic [7:0]  td [0:2] = '{8'h5a, 8'ha5, 8'h3c};
  int          n_mismatch = 0;
  int          checks = 0;
  wire  [7:0]  dq = dataOe ? dataOut : mQ;
  wire         busyN = !((hwSaveOe && !hwSaveOut) || pullLow);
  always #20 mclk = ~mclk;
  nvsc_host #(.SAVE_CYC(20), .RESTORE_CYC(20), .POWERUP_CYC(20)) nvsc_host_i (
    .mclk(mclk), .rst_b(rst_b), .reqValid(reqValid), .reqOp(reqOp), .reqAddr(reqAddr),
    .reqData(reqData), .hwSaveReq(hwSaveReq), .reqReady(reqReady), .rspValid(rspValid),
    .rspData(rspData), .wroteFlag(wroteFlag), .address_lines(addrLines), .dataOut(dataOut),
    .dataOe(dataOe), .dataIn(dq), .chipEn_b(chipEn_b), .outEn_b(outEn_b),
    .writeEn_b(writeEn_b), .hwSaveOut(hwSaveOut), .hwSaveOe(hwSaveOe), .hw_save_busy_n(busyN));
  nvsc_mem_model nvsc_mem_model_i (.mclk(mclk), .addr(addrLines), .dq(dq),
    .chipEn_b(chipEn_b), .outEn_b(outEn_b), .writeEn_b(writeEn_b), .busyN(busyN),
    .capLow(capLow), .mQ(mQ), .mOe(mOe), .pullLow(pullLow));
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [1:0] o, input logic [14:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    #1;
    {reqValid, reqOp, reqAddr, reqData} = {1'b1, o, a, d};
    do begin
      @(posedge mclk);
      n++;
    end while (reqReady !== 1'b1 && n < 3000);
    #1;
    reqValid = 1'b0;
    while (rspValid !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    q = rspData;
    if (n >= 3000) begin
      n_mismatch++;
      $display("Error at %0t: request timed out", $time);
      end_of_test;
    end
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_rw;
    logic [7:0] q;
    for (int i = 0; i < 3; i++) op(OP_WRITE, ta[i], td[i], q);
    for (int i = 0; i < 3; i++) begin
      op(OP_READ, ta[i], 8'h00, q);
      chk(q, td[i]);
    end
    chk({7'h0, wroteFlag}, 8'h01);
    $display("Test write and read done");
  endtask
  task automatic t_sw;
    logic [7:0] q;
    op(OP_SAVE, 15'h0000, 8'h00, q);
    chk({7'h0, wroteFlag}, 8'h00);
    op(OP_WRITE, 15'h7fff, 8'h11, q);
    op(OP_READ, 15'h7fff, 8'h00, q);
    chk(q, 8'h11);
    op(OP_RESTORE, 15'h0000, 8'h00, q);
    op(OP_READ, 15'h7fff, 8'h00, q);
    chk(q, 8'ha5);
    $display("Test software save and restore done");
  endtask
  task automatic t_hw;
    logic [7:0] q;
    int n;
    n = 0;
    op(OP_WRITE, 15'h0000, 8'h77, q);
    @(posedge mclk);
    #1;
    hwSaveReq = 1'b1;
    while (busyN !== 1'b0 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    chk({7'h0, busyN}, 8'h00);
    if (n >= 100) end_of_test;
    #1;
    hwSaveReq = 1'b0;
    op(OP_WRITE, 15'h0000, 8'h99, q);
    chk({7'h0, busyN}, 8'h01);
    op(OP_READ, 15'h0000, 8'h00, q);
    chk(q, 8'h99);
    op(OP_RESTORE, 15'h0000, 8'h00, q);
    op(OP_READ, 15'h0000, 8'h00, q);
    chk(q, 8'h77);
    // With nothing written since the restore only the request's own three-cycle pull shows.
    @(posedge mclk);
    #1;
    hwSaveReq = 1'b1;
    @(posedge mclk);
    #1;
    hwSaveReq = 1'b0;
    n = 0;
    repeat (30) begin
      @(posedge mclk);
      n += int'(busyN !== 1'b1);
    end
    chk(8'(n), 8'h03);
    // A capacitor drop after a write makes the memory save and hold the busy line itself.
    op(OP_WRITE, 15'h1234, 8'h55, q);
    @(posedge mclk);
    #1;
    capLow = 1'b1;
    @(posedge mclk);
    #1;
    capLow = 1'b0;
    n = 0;
    repeat (4) begin
      @(posedge mclk);
      n += int'(busyN !== 1'b1);
    end
    chk(8'(n), 8'h04);
    n = 0;
    while (busyN !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 100) begin
      n_mismatch++;
      $display("Error at %0t: busy line never released", $time);
      end_of_test;
    end
    repeat (2) @(posedge mclk);
    op(OP_RESTORE, 15'h0000, 8'h00, q);
    op(OP_READ, 15'h1234, 8'h00, q);
    chk(q, 8'h55);
    $display("Test line-requested save done");
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    t_rw;
    t_sw;
    t_hw;
    end_of_test;
  end
endmodule
